// ===== hw/mpps_phase_sequencer.v
/*
 * Phase sequencer for a six-phase buck controller: strap sampling,
 * interleaved firing, light-load phase shedding and current balancing.
 * Assumes external drivers decode low, high and mid-level output codes,
 * straps are stable at reset release, and current samples are per cycle.
 */
// Contract
// - Cycle is interval between pulse terminations.
// - Six phases fire one sixth apart ascending.
// - Sixth output strapped high gives five phases.
// - Fifth and sixth strapped gives four phases.
// - One to six phases, equal spacing outside light load.
// - Light-load request drops to one or two.
// - Kept phases depend on configured phase count.
// - Soft-start strap alone picks the one- or two-phase target.
// - Enter and exit behaviour differs per configuration.
// - Dropped phase low briefly, then mid level unless two-phase uncoupled.
// - Diode-emulation variant emits three-level pattern.
// - Other variant emits no three-level emulation pattern.
// - Soft-start or hiccup runs all phases.
// - Request honoured only after regulator ready.
// - Request release restores all configured phases.
// - Fault and parking mid level allowed only while operational.
// - Sense path enabled per strapped outputs.
// - Average equals enabled sum over configured count.
// - Duty trimmed toward the average current.
`timescale 1ns/1ps
`include "mpps_defs.vh"

module mpps_phase_sequencer (
    input wire core_clk,
    input wire reset,
    input wire clkEnable,
    input wire [`MPPS_SLOT_W-1:0] cycleLength,
    input wire [5:1] phaseStrap,
    input wire freqSelectStrap,
    input wire softStartStrap,
    input wire diodeEmulationVariant,
    input wire lightLoadRequestN,
    input wire regulatorReady,
    input wire softStartActive,
    input wire hiccupActive,
    input wire faultActive,
    input wire supplyGood,
    input wire terminationRailEnable,
    input wire powerRailEnable,
    input wire voltageCodeValid,
    input wire [6*`MPPS_CUR_W-1:0] channelCurrentSense,
    output reg [1:0] phaseOut1,
    output reg [1:0] phaseOut2,
    output reg [1:0] phaseOut3,
    output reg [1:0] phaseOut4,
    output reg [1:0] phaseOut5,
    output reg [1:0] phaseOut6,
    output reg [2:0] activeCount,
    output reg lightLoadActive,
    output reg [5:0] senseEnable,
    output reg [`MPPS_CUR_W-1:0] averageCurrent,
    output reg [6*`MPPS_SLOT_W-1:0] dutyTrim,
    output reg cycleBoundary
);

// ****************************************************************
// Helper functions
// ****************************************************************
// Count of configured phases from the strapped-high upper outputs.
function [2:0] strapCount;
    input [5:1] s;
    begin
        if (s[1])
            strapCount = 3'h1;
        else if (s[2])
            strapCount = 3'h2;
        else if (s[3])
            strapCount = 3'h3;
        else if (s[4])
            strapCount = 3'h4;
        else if (s[5])
            strapCount = 3'h5;
        else
            strapCount = 3'h6;
    end
endfunction

// Mask of kept phases in light load, from count and two-phase target.
function [5:0] keepMask;
    input [2:0] n;
    input two;
    begin
        if (!two || n == 3'h1)
            keepMask = 6'h01;
        else if (n == 3'h6)
            keepMask = 6'h09;
        else if (n == 3'h5 || n == 3'h4)
            keepMask = 6'h05;
        else
            keepMask = 6'h03;
    end
endfunction

// Mask of the lowest n phases.
function [5:0] countMask;
    input [2:0] n;
    begin
        countMask = ~(6'h3f << n);
    end
endfunction

// ****************************************************************
// Input synchronisers
// ****************************************************************
// Index 0 is the first flop; only the second stage is read.
reg [1:0] reqSync_q;
reg [1:0] rdySync_q;
reg [1:0] ssSync_q;
reg [1:0] hicSync_q;
reg [1:0] fltSync_q;
reg [1:0] opSync_q;
reg [5:1] strapMeta_q;
reg [5:1] strapSync_q;
reg [1:0] fsMeta_q;
reg [1:0] fsSync_q;
wire operational = supplyGood & terminationRailEnable & powerRailEnable &
    voltageCodeValid;

always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        reqSync_q <= 2'h3;
        rdySync_q <= 2'h0;
        ssSync_q <= 2'h0;
        hicSync_q <= 2'h0;
        fltSync_q <= 2'h0;
        opSync_q <= 2'h0;
        strapMeta_q <= 5'h00;
        strapSync_q <= 5'h00;
        fsMeta_q <= 2'h0;
        fsSync_q <= 2'h0;
    end else if (clkEnable) begin
        reqSync_q <= {reqSync_q[0], lightLoadRequestN};
        rdySync_q <= {rdySync_q[0], regulatorReady};
        ssSync_q <= {ssSync_q[0], softStartActive};
        hicSync_q <= {hicSync_q[0], hiccupActive};
        fltSync_q <= {fltSync_q[0], faultActive};
        opSync_q <= {opSync_q[0], operational};
        strapMeta_q <= phaseStrap;
        strapSync_q <= strapMeta_q;
        fsMeta_q <= {softStartStrap, freqSelectStrap};
        fsSync_q <= fsMeta_q;
    end
end

// ****************************************************************
// Strap capture
// ****************************************************************
// Straps are taken once, a few cycles after release, so the
// synchronisers have settled; later pin changes are ignored.
reg [1:0] strapWait_q;
reg strapDone_q;
reg [2:0] cfgCount_q;
reg cfgTwo_q;
reg cfgCoupled_q;

always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        strapWait_q <= 2'h0;
        strapDone_q <= 1'b0;
        cfgCount_q <= 3'h6;
        cfgTwo_q <= 1'b0;
        cfgCoupled_q <= 1'b0;
        senseEnable <= 6'h00;
    end else if (clkEnable && !strapDone_q) begin
        strapWait_q <= strapWait_q + 2'h1;
        if (strapWait_q == `MPPS_STRAP_WAIT) begin
            strapDone_q <= 1'b1;
            cfgCount_q <= strapCount(strapSync_q);
            cfgTwo_q <= fsSync_q[1];
            cfgCoupled_q <= fsSync_q[0];
            senseEnable <= countMask(strapCount(strapSync_q));
        end
    end
end

// ****************************************************************
// Cycle timer and light-load mode
// ****************************************************************
reg [`MPPS_SLOT_W-1:0] cycCnt_q;
reg [5:0] dropLow_q;
reg [2:0] triCnt_q;
wire allPhases = ssSync_q[1] | hicSync_q[1];
wire wantLight = strapDone_q & !reqSync_q[1] & rdySync_q[1] &
    !allPhases;
wire boundary = (cycCnt_q == cycleLength - `MPPS_SLOT_W'h1) | ~|cycleLength;
wire [5:0] keep = keepMask(cfgCount_q, cfgTwo_q);

always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        cycCnt_q <= `MPPS_SLOT_W'h0;
        lightLoadActive <= 1'b0;
        activeCount <= 3'h0;
        cycleBoundary <= 1'b0;
        triCnt_q <= 3'h0;
    end else if (clkEnable) begin
        cycleBoundary <= boundary & strapDone_q;
        cycCnt_q <= boundary ? `MPPS_SLOT_W'h0 :
            cycCnt_q + `MPPS_SLOT_W'h1;
        if (boundary && strapDone_q) begin
            // A mode change takes effect only between cycles.
            lightLoadActive <= wantLight;
            activeCount <= wantLight ? (cfgTwo_q && cfgCount_q != 3'h1 ?
                3'h2 : 3'h1) : cfgCount_q;
            triCnt_q <= (triCnt_q == `MPPS_TRI_LEN - 3'h1) ? 3'h0 :
                triCnt_q + 3'h1;
        end
    end
end

// ****************************************************************
// Per-phase firing, shedding and balancing
// ****************************************************************
reg [`MPPS_CUR_W+2:0] curSum;
integer k;
always @* begin
    curSum = {(`MPPS_CUR_W+3){1'b0}};
    for (k = 0; k < `MPPS_PHASES; k = k + 1) begin
        if (senseEnable[k])
            curSum = curSum + {3'h0,
                channelCurrentSense[k*`MPPS_CUR_W +: `MPPS_CUR_W]};
    end
end

// The mean of the summed samples never exceeds one sample, so only the
// low bits of the quotient carry meaning.
wire [`MPPS_CUR_W+2:0] avgFull = curSum / {12'h000, cfgCount_q};

always @(posedge core_clk or posedge reset) begin
    if (reset)
        averageCurrent <= {`MPPS_CUR_W{1'b0}};
    else if (clkEnable && boundary && strapDone_q)
        averageCurrent <= avgFull[`MPPS_CUR_W-1:0];
end

wire [1:0] lvl [0:5];
genvar g;
generate
    for (g = 0; g < `MPPS_PHASES; g = g + 1) begin : gPhase
        reg [1:0] lvl_q;
        reg [5:0] lowCnt_q;
        reg dropped_q;
        // Slot offset is g/N of the cycle; in light load phase g keeps
        // its normal slot, so kept phases are evenly spaced only for N of 2, 4 or 6.
        wire [31:0] off = ({16'h0000, cycleLength} * g) /
            cfgCount_q;
        wire [`MPPS_SLOT_W-1:0] width = cycleLength / `MPPS_PULSE_DIV;
        wire [`MPPS_SLOT_W:0] rel = {1'b0, cycCnt_q} -
            {1'b0, off[`MPPS_SLOT_W-1:0]};
        wire [`MPPS_SLOT_W-1:0] pos = rel[`MPPS_SLOT_W] ?
            rel[`MPPS_SLOT_W-1:0] + cycleLength : rel[`MPPS_SLOT_W-1:0];
        wire on = pos < width;
        wire configured = g < cfgCount_q;
        wire shed = lightLoadActive & configured & !keep[g];
        wire [`MPPS_SLOT_W-1:0] trim = channelCurrentSense[g*
            `MPPS_CUR_W +: `MPPS_CUR_W] > averageCurrent ?
            `MPPS_SLOT_W'h0 : `MPPS_SLOT_W'h1;
        always @(posedge core_clk or posedge reset) begin
            if (reset) begin
                lvl_q <= `MPPS_LVL_LOW;
                lowCnt_q <= 6'h00;
                dropped_q <= 1'b0;
                dutyTrim[g*`MPPS_SLOT_W +: `MPPS_SLOT_W] <=
                    `MPPS_SLOT_W'h0;
            end else if (clkEnable) begin
                dutyTrim[g*`MPPS_SLOT_W +: `MPPS_SLOT_W] <= trim;
                dropped_q <= shed;
                if (!configured || !strapDone_q) begin
                    lvl_q <= `MPPS_LVL_LOW;
                end else if (shed) begin
                    if (!dropped_q)
                        lowCnt_q <= 6'h00;
                    else if (lowCnt_q < `MPPS_DROP_LOW_CNT)
                        lowCnt_q <= lowCnt_q + 6'h01;
                    // A coupled set or a one-phase target is parked at mid level, otherwise low.
                    lvl_q <= (lowCnt_q >= `MPPS_DROP_LOW_CNT &&
                        opSync_q[1] && (cfgCoupled_q || !cfgTwo_q)) ?
                        `MPPS_LVL_MID : `MPPS_LVL_LOW;
                end else if (fltSync_q[1] && opSync_q[1]) begin
                    lvl_q <= `MPPS_LVL_MID;
                end else if (lightLoadActive && diodeEmulationVariant &&
                        triCnt_q == 3'h0 && !on) begin
                    lvl_q <= `MPPS_LVL_MID;
                end else begin
                    lvl_q <= on ? `MPPS_LVL_HIGH : `MPPS_LVL_LOW;
                end
            end
        end
        assign lvl[g] = lvl_q;
    end
endgenerate

always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        phaseOut1 <= `MPPS_LVL_LOW;
        phaseOut2 <= `MPPS_LVL_LOW;
        phaseOut3 <= `MPPS_LVL_LOW;
        phaseOut4 <= `MPPS_LVL_LOW;
        phaseOut5 <= `MPPS_LVL_LOW;
        phaseOut6 <= `MPPS_LVL_LOW;
    end else if (clkEnable) begin
        phaseOut1 <= lvl[0];
        phaseOut2 <= lvl[1];
        phaseOut3 <= lvl[2];
        phaseOut4 <= lvl[3];
        phaseOut5 <= lvl[4];
        phaseOut6 <= lvl[5];
    end
end

endmodule // mpps_phase_sequencer

// ===== hw/mpps_defs.vh
/*
 * Constants for the multiphase phase sequencer: output level codes,
 * timing figures and current-sense widths.
 * Assumes a 250 MHz core clock and is included by its bare name.
 */
`ifndef MPPS_DEFS_VH
`define MPPS_DEFS_VH

// ****************************************************************
// Output level codes
// ****************************************************************
`define MPPS_LVL_LOW 2'h0
`define MPPS_LVL_HIGH 2'h1
`define MPPS_LVL_MID 2'h2

// ****************************************************************
// Geometry and timing
// ****************************************************************
`define MPPS_PHASES 6
`define MPPS_SLOT_W 16
`define MPPS_CUR_W 12
`define MPPS_CLK_MHZ 250
`define MPPS_DROP_LOW_NS 200
`define MPPS_DROP_LOW_CYC ((`MPPS_DROP_LOW_NS * `MPPS_CLK_MHZ + 999) / 1000)
// The same drop-low figure at counter width; keep the two in step.
`define MPPS_DROP_LOW_CNT 6'h32
`define MPPS_PULSE_DIV 16'h0002
`define MPPS_TRI_LEN 3'h4
// Enabled edges after reset release before the straps are taken.
`define MPPS_STRAP_WAIT 2'h3

`endif

// ===== verif/mpps_driver_model.sv
/*
 * Power-stage driver model: request pin with a weak pull-up, and a decoder
 * that notes the mid-level marker of the diode-emulation pattern.
 * Assumes phase codes arrive from the sequencer on the same clock.
 */
`timescale 1ns/1ps
`include "mpps_defs.vh"
module mpps_driver_model (
    input wire core_clk,
    input wire reqDrive,
    input wire reqOe,
    input wire clear,
    input wire [1:0] phaseCode,
    output wire lightLoadRequestN,
    output reg emulSeen
);
    // A released request pin floats up, so it must read as inactive.
    assign lightLoadRequestN = reqOe ? reqDrive : 1'b1;
    always @(posedge core_clk) begin
        if (clear) begin
            emulSeen <= 1'b0;
        end else if (phaseCode == `MPPS_LVL_MID) begin
            emulSeen <= 1'b1;
        end
    end
endmodule // mpps_driver_model

// ===== verif/mpps_seq_props.sv
/*
 * Port checker for the phase sequencer, bound at the foot of this file.
 * Assumes mode inputs are held for several cycles around each change.
 */
`timescale 1ns/1ps
module mpps_seq_props (
    input wire core_clk,
    input wire reset,
    input wire lightLoadRequestN,
    input wire regulatorReady,
    input wire softStartActive,
    input wire hiccupActive,
    input wire [1:0] phaseOut1,
    input wire [1:0] phaseOut2,
    input wire [2:0] activeCount,
    input wire lightLoadActive,
    input wire [5:0] senseEnable,
    input wire cycleBoundary
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence llEnter;
        $rose(lightLoadActive);
    endsequence
    sequence reqRelease;
        $rose(lightLoadRequestN) ##3 lightLoadActive;
    endsequence
    chk_ll_ready: assert property (llEnter |-> $past(regulatorReady, 3)
        && !$past(lightLoadRequestN, 3)) else $error("early light load");
    chk_ll_startup: assert property (llEnter |-> !$past(softStartActive, 3)
        && !$past(hiccupActive, 3)) else $error("light load in start-up");
    chk_ll_exit: assert property (reqRelease |-> ##[0:80] !lightLoadActive)
        else $error("light load kept after release");
    chk_ll_count: assert property (lightLoadActive |->
        (activeCount == 3'h1 || activeCount == 3'h2)) else $error("bad count");
    chk_cycle_period: assert property (cycleBoundary |=>
        (!cycleBoundary) [*8]) else $error("boundary too soon");
    chk_count_boundary: assert property (($changed(activeCount)
        && $past(activeCount) != 3'h0) |-> (cycleBoundary
        || $past(cycleBoundary))) else $error("count moved mid-cycle");
    chk_sense_mask: assert property ((!lightLoadActive && $stable(activeCount)
        && activeCount != 3'h0) |-> senseEnable == (6'h3f >> (3'h6
        - activeCount))) else $error("sense mask wrong");
    chk_code_legal: assert property (phaseOut1 != 2'h3 && phaseOut2 != 2'h3)
        else $error("illegal level code");
endmodule // mpps_seq_props
bind mpps_phase_sequencer mpps_seq_props chk (.core_clk, .reset,
    .lightLoadRequestN, .regulatorReady, .softStartActive, .hiccupActive,
    .phaseOut1, .phaseOut2, .activeCount, .lightLoadActive, .senseEnable,
    .cycleBoundary);

// ===== verif/mpps_phase_sequencer_tb.sv
/*
 * Self-checking bench: strap sweep, pulse spacing, balancing, and
 * light-load entry and exit against a model built in the bench.
 * Assumes the checker binds itself and the clock runs at 250 MHz.
 */
`timescale 1ns/1ps
`include "mpps_defs.vh"
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin nFail++; \
    $display("[ERR] %0t got %0d want %0d", $time, a, b); end end
module mpps_phase_sequencer_tb;
    reg core_clk = 0, reset = 1, clkEnable = 1, freqSelectStrap = 0;
    reg softStartStrap = 0, diodeEmulationVariant = 0, regulatorReady = 0;
    reg softStartActive = 0, hiccupActive = 0, reqDrive = 1, reqOe = 0;
    reg clear = 1, faultActive = 0, supplyGood = 1;
    reg [15:0] cycleLength = 16'h003c;
    reg [5:1] phaseStrap = 5'h00;
    reg [71:0] channelCurrentSense = 72'h0;
    wire [1:0] phaseOut1, phaseOut2, phaseOut3, phaseOut4, phaseOut5;
    wire [1:0] phaseOut6;
    wire [2:0] activeCount;
    wire [5:0] senseEnable;
    wire [11:0] averageCurrent;
    wire [95:0] dutyTrim;
    wire lightLoadActive, cycleBoundary, lightLoadRequestN, emulSeen;
    wire [11:0] poAll = {phaseOut6, phaseOut5, phaseOut4, phaseOut3,
        phaseOut2, phaseOut1};
    int nFail = 0, numChecks = 0, seed = 32'h0000_fd47, n, tgt, sum;
    int lowRun = 0, lastLow = 0, expAvg = 0;
    logic [11:0] frz;
    int t[6];
    mpps_phase_sequencer uut (.core_clk, .reset, .clkEnable, .cycleLength,
        .phaseStrap, .freqSelectStrap, .softStartStrap,
        .diodeEmulationVariant, .lightLoadRequestN, .regulatorReady,
        .softStartActive, .hiccupActive, .faultActive,
        .supplyGood, .terminationRailEnable(1'b1),
        .powerRailEnable(1'b1), .voltageCodeValid(1'b1),
        .channelCurrentSense, .phaseOut1, .phaseOut2, .phaseOut3,
        .phaseOut4, .phaseOut5, .phaseOut6, .activeCount, .lightLoadActive,
        .senseEnable, .averageCurrent, .dutyTrim, .cycleBoundary);
    mpps_driver_model drv (.core_clk, .reqDrive, .reqOe, .clear,
        .phaseCode(phaseOut1), .lightLoadRequestN, .emulSeen);
    initial forever #2 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        if (phaseOut2 === `MPPS_LVL_MID && lowRun > 0) lastLow = lowRun;
        lowRun = (phaseOut2 === `MPPS_LVL_LOW) ? lowRun + 1 : 0;
    end
    // Reference average, taken at the edge where the design takes it.
    always @(posedge core_clk) begin
        int s;
        s = 0;
        for (int p = 0; p < n; p++)
            s += channelCurrentSense[12*p+:12];
        if (n > 0) expAvg <= s / n;
    end
    always @(negedge core_clk)
        if (!reset && cycleBoundary === 1'b1)
            `CHK(averageCurrent, 12'(expAvg))
    function automatic bit kept(int n, int tgt, int p);
        return p == 0 || (tgt == 2 && p == (n == 6 ? 3 : n >= 4 ? 2 : 1));
    endfunction
    task automatic waitBnd(input int k);
        int c;
        for (c = 0; k > 0 && c < 2000; c++) begin
            @(negedge core_clk);
            if (cycleBoundary === 1'b1) k--;
        end
    endtask
    task automatic measure();
        logic [11:0] prev;
        prev = poAll;
        t = '{default: -1};
        for (int c = 0; c < 120; c++) begin
            @(negedge core_clk);
            for (int p = 0; p < 6; p++)
                if (t[p] < 0 && poAll[2*p+:2] === `MPPS_LVL_HIGH
                    && prev[2*p+:2] !== `MPPS_LVL_HIGH) t[p] = c;
            prev = poAll;
        end
    endtask
    task automatic reportAndStop();
        $display("checks %0d failures %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ********************************
    // Strap sweep and light-load runs
    // ********************************
    initial begin
        for (n = 6; n >= 1; n--) begin
            reset = 1;
            reqOe = 0;
            regulatorReady = 0;
            phaseStrap = 5'h1f << (n - 1);
            freqSelectStrap = n[1];
            softStartStrap = n[0] ^ n[1];
            diodeEmulationVariant = n[0];
            repeat (5) @(negedge core_clk);
            reset = 0;
            waitBnd(3);
            `CHK(activeCount, n[2:0])
            measure();
            `CHK(t[0] >= 0, 1'b1)
            for (int p = 1; p < n; p++)
                `CHK((t[p] - t[0] + 60) % 60, p * 60 / n)
            sum = 0;
            for (int p = 0; p < 6; p++) begin
                channelCurrentSense[12*p+:12] = $random(seed);
                if (p < n) sum += channelCurrentSense[12*p+:12];
            end
            waitBnd(2);
            `CHK(averageCurrent, 12'(sum / n))
            for (int p = 0; p < n; p++)
                `CHK(dutyTrim[16*p+:16], 16'(channelCurrentSense[12*p+:12] <= sum / n))
            faultActive = 1;
            repeat (8) @(negedge core_clk);
            `CHK(phaseOut1, `MPPS_LVL_MID)
            supplyGood = 0;
            repeat (8) @(negedge core_clk);
            `CHK(phaseOut1 === `MPPS_LVL_MID, 1'b0)
            faultActive = 0;
            supplyGood = 1;
            repeat (8) @(negedge core_clk);
            clkEnable = 0;
            frz = poAll;
            repeat (30) @(negedge core_clk);
            `CHK(poAll, frz)
            clkEnable = 1;
            if (n > 1) begin
                reqOe = 1;
                reqDrive = 0;
                waitBnd(2);
                `CHK(lightLoadActive, 1'b0)
                regulatorReady = 1;
                softStartActive = n[0];
                hiccupActive = !n[0];
                waitBnd(2);
                `CHK(lightLoadActive, 1'b0)
                softStartActive = 0;
                hiccupActive = 0;
                lastLow = 0;
                clear = 1;
                waitBnd(2);
                clear = 0;
                tgt = softStartStrap ? 2 : 1;
                `CHK(lightLoadActive, 1'b1)
                `CHK(activeCount, tgt[2:0])
                measure();
                for (int p = 0; p < n; p++)
                    `CHK(t[p] >= 0, kept(n, tgt, p))
                waitBnd(4);
                `CHK(emulSeen, diodeEmulationVariant)
                if (!freqSelectStrap && !softStartStrap) begin
                    `CHK(phaseOut2, `MPPS_LVL_MID)
                    `CHK(lastLow >= `MPPS_DROP_LOW_CYC, 1'b1)
                end
                reqOe = 0;
                waitBnd(2);
                `CHK(lightLoadActive, 1'b0)
                `CHK(activeCount, n[2:0])
            end
        end
        reportAndStop();
    end
    // The whole sweep needs about 27 us, so this only trips on a hang.
    initial begin
        #200_000;
        nFail++;
        reportAndStop();
    end
endmodule // mpps_phase_sequencer_tb
